// ==== cmpctl_consts.svh ====
// Purpose: constants for the comparator control block
// Assumes: apb register bus, 20 MHz clk
// Notes:   offsets and layouts are named here once
// How it works
// [RL1] control bits 3..1 pick minus input: a3, a4, bandgap, ladder, a6, a7.
// [RL2] control bit 0 picks plus input: ladder or port line a4.
// [RL3] control bit 7 enables; minus code 000 is a3, plus 0 is ladder.
// [RL4] minus code 011 is ladder, plus 1 is a4, inversion applies.
// [RL5] reference bit 7 forces result onto port line a0, overriding direction.
// [RL6] control bit 5 selects direct or timer-2-clock sampled result.
// [RL7] control bit 4 inverts the result polarity.
// [RL8] final result raises interrupt and reads back as control bit 6.
// [RL9] reference bits 5..4 pick one of four ladder ranges.
// [RL10] reference bits 3..0 pick one of sixteen ladder taps.
// [RL11] ladder fraction: (n+9)/32, (n+1)/24, (n+9)/40, (n+1)/32 of supply.
// [RL12] software disables digital input buffers of pins used as analog inputs.
// [RL13] sampled mode holds result between timer pulses; all uses see it.
// [RL14] comparator output synchronised in two stages; changes request interrupt.
`ifndef CMPCTL_CONSTS_SVH
`define CMPCTL_CONSTS_SVH
`define CMPCTL_OFF_CTRL     12'h000
`define CMPCTL_OFF_REFSEL   12'h004
`define CMPCTL_OFF_STATUS   12'h008
`define CMPCTL_OFF_CLEAR    12'h00c
`define CMPCTL_OFF_INTEN    12'h010
`define CMPCTL_CTRL_RST     8'h00
`define CMPCTL_REF_RST      8'h00
`define CMPCTL_B_EN         7
`define CMPCTL_B_OUT        6
`define CMPCTL_B_SAMP       5
`define CMPCTL_B_INV        4
`define CMPCTL_B_PLUS       0
`define CMPCTL_B_FORCE      7
`define CMPCTL_F_MINUS_HI   3
`define CMPCTL_F_MINUS_LO   1
`define CMPCTL_F_RNG_HI     5
`define CMPCTL_F_RNG_LO     4
`define CMPCTL_F_TAP_HI     3
`define CMPCTL_F_TAP_LO     0
`define CMPCTL_MINUS_A3     3'h0
`define CMPCTL_MINUS_A4     3'h1
`define CMPCTL_MINUS_BG     3'h2
`define CMPCTL_MINUS_LAD    3'h3
`define CMPCTL_MINUS_A6     3'h4
`define CMPCTL_MINUS_A7     3'h5
`define CMPCTL_RNG_0        2'h0
`define CMPCTL_RNG_1        2'h1
`define CMPCTL_RNG_2        2'h2
`define CMPCTL_ADD_9        6'h09
`define CMPCTL_ADD_1        6'h01
`define CMPCTL_DEN_32       6'h20
`define CMPCTL_DEN_24       6'h18
`define CMPCTL_DEN_40       6'h28
`endif

// ==== cmpctl_pkg.sv ====
// Purpose: shared types for the comparator control block
// Assumes: used with cmpctl_consts.svh
// Notes:   types only
package cmpctl_pkg;
	typedef enum logic [1:0] {
		CMPCTL_ST_DIRECT  = 2'h0,
		CMPCTL_ST_SAMPLED = 2'h1
	} cmpctl_mode_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] refsel;
		logic       sync1;
		logic       sync2;
		logic       held;
		logic       fin_prev;
		logic       tck_prev;
		logic [1:0] sts;
		logic [1:0] inten;
		logic [31:0] prdata;
		cmpctl_mode_t mode;
	} cmpctl_state_t;
endpackage

// ==== cmpctl_if.sv ====
// Purpose: config passed to the ladder decoder and routing selections passed back
// Assumes: single clock
// Notes:   carries config in, analog selections out
`timescale 1ns/10ps
interface cmpctl_if;
	logic [7:0] ctrl;
	logic [7:0] refsel;
	logic [2:0] minus_sel;
	logic       plus_sel;
	logic [5:0] lad_num;
	logic [5:0] lad_den;
	modport cfg (output ctrl, output refsel, input minus_sel, input plus_sel,
		input lad_num, input lad_den);
	modport dec (input ctrl, input refsel, output minus_sel, output plus_sel,
		output lad_num, output lad_den);
endinterface

// ==== cmpctl_ladder.sv ====
// Purpose: decode input routing and ladder fraction
// Assumes: analog core consumes the selections
// Notes:   purely combinational
`timescale 1ns/10ps
`include "cmpctl_consts.svh"
module cmpctl_ladder (
	cmpctl_if.dec sel
);
	always_comb begin
		logic [5:0] tap;
		tap = {2'h0, sel.refsel[`CMPCTL_F_TAP_HI:`CMPCTL_F_TAP_LO]}; // see [RL10]
		sel.minus_sel = sel.ctrl[`CMPCTL_F_MINUS_HI:`CMPCTL_F_MINUS_LO]; // see [RL1] see [RL3] see [RL4]
		sel.plus_sel  = sel.ctrl[`CMPCTL_B_PLUS]; // see [RL2]
		// see [RL9] see [RL10] see [RL11]
		case (sel.refsel[`CMPCTL_F_RNG_HI:`CMPCTL_F_RNG_LO])
			`CMPCTL_RNG_0: begin
				sel.lad_num = tap + `CMPCTL_ADD_9;
				sel.lad_den = `CMPCTL_DEN_32;
			end
			`CMPCTL_RNG_1: begin
				sel.lad_num = tap + `CMPCTL_ADD_1;
				sel.lad_den = `CMPCTL_DEN_24;
			end
			`CMPCTL_RNG_2: begin
				sel.lad_num = tap + `CMPCTL_ADD_9;
				sel.lad_den = `CMPCTL_DEN_40;
			end
			default: begin
				sel.lad_num = tap + `CMPCTL_ADD_1;
				sel.lad_den = `CMPCTL_DEN_32;
			end
		endcase
	end
endmodule

// ==== cmpctl_top.sv ====
// Purpose: comparator control registers, result path and interrupt
// Assumes: apb slave, 20 MHz clk, async comparator and timer inputs
// Notes:   analog core sees enable and selections as plain outputs
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "cmpctl_consts.svh"
module cmpctl_top (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        comp_raw,
	input  wire logic        timer_two_prescaled_clock,
	output logic             comp_enable,
	output logic       [2:0] minus_sel,
	output logic             plus_sel,
	output logic       [5:0] lad_num,
	output logic       [5:0] lad_den,
	output logic             port_a_line0_out,
	output logic             port_a_line0_oe,
	output logic             irq
);
	cmpctl_pkg::cmpctl_state_t s_r;
	cmpctl_pkg::cmpctl_state_t s_nxt;
	logic                      tck_s1_r;
	logic                      tck_s2_r;
	logic                      fin;
	logic                      tck_pulse;
	logic                      wr;
	logic                      rd;
	logic                      hit;
	cmpctl_if                  sel ();

	////////////////////////////////////////////////////////////////
	// timer clock is asynchronous: two stages before edge detect
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_s1_r <= 1'b0;
			tck_s2_r <= 1'b0;
		end else begin
			tck_s1_r <= timer_two_prescaled_clock;
			tck_s2_r <= tck_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////
	assign sel.ctrl   = s_r.ctrl;
	assign sel.refsel = s_r.refsel;
	cmpctl_ladder u_ladder (
		.sel (sel.dec)
	);
	assign minus_sel = sel.minus_sel;
	assign plus_sel  = sel.plus_sel;
	assign lad_num   = sel.lad_num;
	assign lad_den   = sel.lad_den;

	function automatic logic is_off(input logic [11:0] a, input logic [11:0] o);
		is_off = (a == o);
	endfunction

	assign hit = is_off(paddr, `CMPCTL_OFF_CTRL) | is_off(paddr, `CMPCTL_OFF_REFSEL)
		| is_off(paddr, `CMPCTL_OFF_STATUS) | is_off(paddr, `CMPCTL_OFF_CLEAR)
		| is_off(paddr, `CMPCTL_OFF_INTEN);
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign tck_pulse = tck_s2_r & ~s_r.tck_prev;

	// final result: sampled value held, or direct sync value, then inverted when control bit 4 is set
	always_comb begin
		logic r;
		r = 1'b0;
		if (s_r.mode == cmpctl_pkg::CMPCTL_ST_SAMPLED) begin
			r = s_r.held; // see [RL13]
		end else begin
			r = s_r.sync2;
		end
		fin = r ^ s_r.ctrl[`CMPCTL_B_INV]; // see [RL7] see [RL4]
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		logic [1:0] ev;
		ev = 2'h0;
		s_nxt = s_r;
		s_nxt.sync1 = comp_raw; // see [RL14]
		s_nxt.sync2 = s_r.sync1;
		s_nxt.tck_prev = tck_s2_r;
		if (tck_pulse) begin
			s_nxt.held = s_r.sync2; // see [RL13]
		end
		s_nxt.mode = s_r.ctrl[`CMPCTL_B_SAMP] ? cmpctl_pkg::CMPCTL_ST_SAMPLED
			: cmpctl_pkg::CMPCTL_ST_DIRECT; // see [RL6]
		s_nxt.fin_prev = fin;
		// bit0 rise, bit1 fall of the final result
		ev[0] = fin & ~s_r.fin_prev; // see [RL14] see [RL8]
		ev[1] = ~fin & s_r.fin_prev;
		if (wr && is_off(paddr, `CMPCTL_OFF_CTRL)) begin
			// readback bit is not writable
			s_nxt.ctrl = {pwdata[`CMPCTL_B_EN], 1'b0, pwdata[`CMPCTL_B_SAMP:`CMPCTL_B_PLUS]};
		end
		if (wr && is_off(paddr, `CMPCTL_OFF_REFSEL)) begin
			s_nxt.refsel = pwdata[7:0];
		end
		if (wr && is_off(paddr, `CMPCTL_OFF_INTEN)) begin
			s_nxt.inten = pwdata[1:0];
		end
		if (wr && is_off(paddr, `CMPCTL_OFF_CLEAR)) begin
			s_nxt.sts = s_r.sts & ~pwdata[1:0];
		end
		// set wins over a clear in the same cycle
		s_nxt.sts = s_nxt.sts | ev;
		if (rd) begin
			if (is_off(paddr, `CMPCTL_OFF_CTRL)) begin
				s_nxt.prdata = {24'h00_0000, s_r.ctrl[`CMPCTL_B_EN], fin,
					s_r.ctrl[`CMPCTL_B_SAMP:`CMPCTL_B_PLUS]}; // see [RL8]
			end else if (is_off(paddr, `CMPCTL_OFF_REFSEL)) begin
				s_nxt.prdata = {24'h00_0000, s_r.refsel};
			end else if (is_off(paddr, `CMPCTL_OFF_STATUS)) begin
				s_nxt.prdata = {30'h0000_0000, s_r.sts};
			end else if (is_off(paddr, `CMPCTL_OFF_INTEN)) begin
				s_nxt.prdata = {30'h0000_0000, s_r.inten};
			end else begin
				s_nxt.prdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{ctrl: `CMPCTL_CTRL_RST, refsel: `CMPCTL_REF_RST, sync1: 1'b0,
				sync2: 1'b0, held: 1'b0, fin_prev: 1'b0, tck_prev: 1'b0,
				sts: 2'h0, inten: 2'h0, prdata: 32'h0000_0000,
				mode: cmpctl_pkg::CMPCTL_ST_DIRECT};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = s_r.prdata;
	assign comp_enable = s_r.ctrl[`CMPCTL_B_EN]; // see [RL3]
	// forced output overrides the pin's own direction setting
	assign port_a_line0_oe  = s_r.refsel[`CMPCTL_B_FORCE]; // see [RL5]
	assign port_a_line0_out = s_r.refsel[`CMPCTL_B_FORCE] & fin; // see [RL5]
	assign irq = |(s_r.sts & s_r.inten);
endmodule

// ==== ccl_partner.sv ====
// Purpose: analog comparator core and timer clock stand-in
// Assumes: driven by the bench, unrelated to clk
// Notes:   comparator output sits low while disabled
`timescale 1ns/10ps
module ccl_partner (
	input  wire logic level,
	input  wire logic enable,
	input  wire logic tick_req,
	output logic      comp_raw,
	output logic      tck
);
	initial begin
		comp_raw = 1'b0;
		tck = 1'b0;
	end
	// odd delay keeps edges off the clk grid
	// analog level feeds only the comparator; pin digital buffers stay off
	always @(level or enable) comp_raw <= #7 enable & level;
	// timer clock only pulses on request, still otherwise
	always @(posedge tick_req) begin
		tck = 1'b1;
		#230 tck = 1'b0;
	end
endmodule

// ==== ccl_asserts.sv ====
// Purpose: port checker for the comparator control block
// Assumes: apb offsets from cmpctl_consts.svh
// Notes:   bound onto cmpctl_top below
`timescale 1ns/10ps
`include "cmpctl_consts.svh"
module ccl_asserts (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        comp_enable,
	input wire logic [2:0]  minus_sel,
	input wire logic        plus_sel,
	input wire logic [5:0]  lad_num,
	input wire logic [5:0]  lad_den,
	input wire logic        port_a_line0_out,
	input wire logic        port_a_line0_oe,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic wa;
	logic wc;
	logic wr;
	assign wa = psel && penable && pwrite;
	assign wc = wa && paddr == `CMPCTL_OFF_CTRL;
	assign wr = wa && paddr == `CMPCTL_OFF_REFSEL;
	////////////////////////////////////////////////////////////////
	AST_ENABLE: assert property (wc |=> comp_enable == $past(pwdata[7]))
		else $error("enable not taken from control write");
	AST_MINUS: assert property (wc |=> minus_sel == $past(pwdata[3:1]))
		else $error("minus select wrong");
	AST_PLUS: assert property (wc |=> plus_sel == $past(pwdata[0]))
		else $error("plus select wrong");
	AST_FORCE_OE: assert property (wr |=> port_a_line0_oe == $past(pwdata[7]))
		else $error("pin enable wrong");
	AST_PIN_IDLE: assert property (!port_a_line0_oe |-> !port_a_line0_out)
		else $error("pin driven while not forced");
	AST_LAD_DEN: assert property (wr |=> lad_den == ($past(pwdata[4]) ?
		($past(pwdata[5]) ? 6'h20 : 6'h18) : ($past(pwdata[5]) ? 6'h28 : 6'h20)))
		else $error("ladder denominator wrong");
	AST_LAD_NUM: assert property (wr |=> lad_num ==
		{2'h0, $past(pwdata[3:0])} + ($past(pwdata[4]) ? 6'h01 : 6'h09))
		else $error("ladder numerator wrong");
	// decoded from the stored range and tap, so steady between writes
	AST_LAD_HOLD: assert property (!wr |=> $stable(lad_den) && $stable(lad_num))
		else $error("ladder moved without a write");
	AST_IRQ_MASK: assert property (wa && paddr == `CMPCTL_OFF_INTEN &&
		pwdata[1:0] == 2'h0 |=> !irq) else $error("irq with all enables off");
	AST_SLVERR: assert property (pslverr == (psel && penable && paddr > `CMPCTL_OFF_INTEN))
		else $error("slave error wrong");
	COV_IRQ: cover property ($rose(irq));
	COV_PIN: cover property (port_a_line0_oe && port_a_line0_out);
	COV_ERR: cover property (pslverr);
endmodule
bind cmpctl_top ccl_asserts u_chk (.*);

// ==== test_comparator_control_logic.sv ====
// Purpose: self-checking bench for the comparator control block
// Assumes: 20 MHz clk, apb master by nba at rising edge
// Notes:   reads are checked off a queue by a monitor
`timescale 1ns/10ps
`include "cmpctl_consts.svh"
module test_comparator_control_logic;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr, comp_raw, timer_two_prescaled_clock, comp_enable, plus_sel;
	logic [2:0]  minus_sel;
	logic [5:0]  lad_num, lad_den;
	logic        port_a_line0_out, port_a_line0_oe, irq;
	logic        level = 1'b0;
	logic        tick_req = 1'b0;
	logic [31:0] seed = 32'hee42_2451;
	logic [31:0] q[$];
	int          failures = 0;
	int          num_checks = 0;
	int          cyc = 0;
	always #25 clk = ~clk;
	cmpctl_top uut (.*);
	ccl_partner u_far (.level(level), .enable(comp_enable), .tick_req(tick_req),
		.comp_raw(comp_raw), .tck(timer_two_prescaled_clock));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// pulse long enough for the two-stage sync to see it
	task automatic tick();
		tick_req <= 1'b1;
		repeat (10) @(posedge clk);
		tick_req <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (psel && penable && !pwrite && pready) check("prdata", prdata, q.pop_front());
		if (cyc == 3000) begin
			failures++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic [5:0] r;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 12; i += 4) rd(i[11:0], 32'h0000_0000);
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			r = {i[1:0], seed[3:0]};
			apb(1'b1, `CMPCTL_OFF_REFSEL, {26'h000_0000, r});
			rd(`CMPCTL_OFF_REFSEL, {26'h000_0000, r});
			check("num", lad_num, r[3:0] + (r[4] ? 6'h01 : 6'h09));
			check("den", lad_den, r[4] ? (r[5] ? 6'h20 : 6'h18) : (r[5] ? 6'h28 : 6'h20));
		end
		apb(1'b1, `CMPCTL_OFF_CTRL, 32'h0000_0080);
		level <= 1'b1;
		repeat (6) @(posedge clk);
		rd(`CMPCTL_OFF_CTRL, 32'h0000_00c0);
		check("sel", {comp_enable, minus_sel, plus_sel}, 5'h10);
		// bit 6 written high must be ignored
		apb(1'b1, `CMPCTL_OFF_REFSEL, 32'h0000_00ad);
		apb(1'b1, `CMPCTL_OFF_CTRL, 32'h0000_00d7);
		repeat (6) @(posedge clk);
		rd(`CMPCTL_OFF_CTRL, 32'h0000_0097);
		check("a0", {port_a_line0_oe, port_a_line0_out, minus_sel, plus_sel}, 6'h27);
		level <= 1'b0;
		repeat (6) @(posedge clk);
		check("a0", port_a_line0_out, 1'b1);
		apb(1'b1, `CMPCTL_OFF_CLEAR, 32'h0000_0003);
		apb(1'b1, `CMPCTL_OFF_INTEN, 32'h0000_0003);
		rd(`CMPCTL_OFF_STATUS, 32'h0000_0000);
		level <= 1'b1;
		repeat (6) @(posedge clk);
		check("irq", irq, 1'b1);
		rd(`CMPCTL_OFF_STATUS, 32'h0000_0002);
		apb(1'b1, `CMPCTL_OFF_CLEAR, 32'h0000_0002);
		repeat (2) @(posedge clk);
		check("irq", irq, 1'b0);
		apb(1'b1, `CMPCTL_OFF_INTEN, 32'h0000_0002);
		level <= 1'b0;
		repeat (6) @(posedge clk);
		check("irq", irq, 1'b0);
		rd(`CMPCTL_OFF_STATUS, 32'h0000_0001);
		apb(1'b1, `CMPCTL_OFF_INTEN, 32'h0000_0000);
		apb(1'b1, `CMPCTL_OFF_CTRL, 32'h0000_00a7);
		tick();
		level <= 1'b1;
		repeat (6) @(posedge clk);
		rd(`CMPCTL_OFF_CTRL, 32'h0000_00a7);
		tick();
		check("a0", port_a_line0_out, 1'b1);
		rd(12'h020, 32'h0000_0000);
		// mid-run reset: outputs and registers fall back to their reset values
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check("rst", {port_a_line0_oe, comp_enable, irq}, 3'h0);
		check("lad", {lad_num, lad_den}, 12'h260);
		rst_n <= 1'b1;
		rd(`CMPCTL_OFF_CTRL, 32'h0000_0000);
		rd(`CMPCTL_OFF_REFSEL, 32'h0000_0000);
		final_report();
	end
endmodule
